/* File: logic/cacp_config_port.v */
// serial setup port: setup write, readback with daisy chain, decoded setup fields
`timescale 1ns/10ps
`include "cacp_defines.vh"
module cacp_config_port (
   input wire clk_in,
   input wire sys_rst_in,
   input wire dev_rst_n_in,
   input wire setup_clk_in,
   input wire setup_data_in,
   input wire readout_clock_in,
   input wire chain_data_in,
   input wire integration_toggle_in,
   input wire [19:0] integration_toggle_result_in,
   output wire readback_data_out,
   output wire [15:0] setup_word_out,
   output wire setup_valid_out,
   output wire readback_active_out,
   output wire int_clk_en_out,
   output wire [1:0] range_sel_out,
   output wire wide_format_out,
   output wire speed_grade_out,
   output wire current_inputs_open_out,
   output wire [19:0] result_word_out,
   output wire timing_fault_out
);
   localparam [5:0] WAIT_CYC = `CACP_WAIT_CYC;
   localparam [71:0] PATTERN = `CACP_CHECK_PATTERN;
   localparam [3:0] REVISION = `CACP_REVISION;

   // reset stretcher: asserted straight from the pin, released on the clock
   // a synchronised release keeps every core flop leaving reset on one edge
   reg rst_meta_reg;
   reg core_rst_n_reg;

   always @(posedge clk_in or negedge dev_rst_n_in) begin
      if (!dev_rst_n_in) begin
         rst_meta_reg <= 1'b0;
         core_rst_n_reg <= 1'b0;
      end else if (sys_rst_in) begin
         rst_meta_reg <= 1'b0;
         core_rst_n_reg <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         core_rst_n_reg <= rst_meta_reg;
      end
   end

   // pin synchronisers
   wire [3:0] pins_sync;

   cacp_sync #(
      .WIDTH(4)
   ) u_pin_sync (
      .clk_in(clk_in),
      .sys_rst_in(sys_rst_in),
      .async_in({setup_clk_in, setup_data_in, readout_clock_in, integration_toggle_in}),
      .sync_out(pins_sync)
   );

   wire chain_sync;

   cacp_sync #(
      .WIDTH(1)
   ) u_chain_sync (
      .clk_in(clk_in),
      .sys_rst_in(sys_rst_in),
      .async_in(chain_data_in),
      .sync_out(chain_sync)
   );

   wire scl_s = pins_sync[3];
   wire sda_s = pins_sync[2];
   wire rck_s = pins_sync[1];
   wire tog_s = pins_sync[0];

   reg scl_prev_reg;
   reg rck_prev_reg;
   reg tog_prev_reg;

   always @(posedge clk_in or negedge core_rst_n_reg) begin
      if (!core_rst_n_reg) begin
         scl_prev_reg <= 1'b0;
         rck_prev_reg <= 1'b0;
         tog_prev_reg <= 1'b0;
      end else begin
         scl_prev_reg <= scl_s;
         rck_prev_reg <= rck_s;
         tog_prev_reg <= tog_s;
      end
   end

   wire scl_fall = scl_prev_reg & ~scl_s;
   wire scl_rise = ~scl_prev_reg & scl_s;
   wire rck_rise = ~rck_prev_reg & rck_s;
   wire tog_edge = tog_prev_reg ^ tog_s;

   // setup write
   reg [15:0] shift_reg;
   reg [4:0] bit_cnt_reg;
   reg [15:0] setup_word_reg;
   reg setup_valid_reg;
   reg rb_active_reg;
   reg rb_copy_reg;
   reg rb_pass_reg;
   reg [9:0] rb_pos_reg;
   reg rb_data_reg;

   // bits after the sixteenth are ignored until the next reset
   wire write_last = scl_fall && (bit_cnt_reg == 5'h0f);

   always @(posedge clk_in or negedge core_rst_n_reg) begin
      if (!core_rst_n_reg) begin
         shift_reg <= 16'h0000;
         bit_cnt_reg <= 5'h00;
         setup_word_reg <= `CACP_SETUP_RST;
         setup_valid_reg <= 1'b0;
      end else if (scl_fall && (bit_cnt_reg < 5'h10)) begin
         // msb arrives first, so shift towards the top
         shift_reg <= {shift_reg[14:0], sda_s};
         bit_cnt_reg <= bit_cnt_reg + 5'h01;
         if (write_last) begin
            // a word only takes effect once all sixteen bits are in
            setup_word_reg <= {shift_reg[14:0], sda_s};
            setup_valid_reg <= 1'b1;
         end
      end
   end

   wire fmt20 = setup_word_reg[`CACP_BIT_FORMAT];

   // readback sequence, one bit per readout rising edge
   // each copy: leading zeros, setup word, revision, zero fill, check pattern;
   // positions come from one counter so both formats share the decode
   wire [9:0] lead = fmt20 ? `CACP_LEAD_20 : `CACP_LEAD_16;
   wire [9:0] pat_start = fmt20 ? `CACP_PAT_START_20 : `CACP_PAT_START_16;
   wire [9:0] total = fmt20 ? `CACP_TOTAL_20 : `CACP_TOTAL_16;
   wire [9:0] off_word = rb_pos_reg - lead;
   wire [9:0] off_rev = off_word - 10'h010;
   wire [9:0] off_pat = rb_pos_reg - pat_start;
   reg seq_bit;

   always @* begin
      seq_bit = 1'b0;
      if (rb_pos_reg < lead) begin
         seq_bit = 1'b0;
      end else if (off_word < 10'h010) begin
         seq_bit = setup_word_reg[4'hf - off_word[3:0]];
      end else if (off_word < 10'h014) begin
         seq_bit = REVISION[2'h3 - off_rev[1:0]];
      end else if (rb_pos_reg < pat_start) begin
         seq_bit = 1'b0;
      end else begin
         // the 16-bit pattern is the leading part of the 20-bit one
         seq_bit = PATTERN[7'h47 - off_pat[6:0]];
      end
   end

   wire last_of_copy = (rb_pos_reg == total - 10'h001);

   always @(posedge clk_in or negedge core_rst_n_reg) begin
      if (!core_rst_n_reg) begin
         rb_active_reg <= 1'b0;
         rb_copy_reg <= 1'b0;
         rb_pass_reg <= 1'b0;
         rb_pos_reg <= 10'h000;
         rb_data_reg <= 1'b0;
      end else if (write_last) begin
         rb_active_reg <= 1'b1;
         rb_copy_reg <= 1'b0;
         rb_pass_reg <= 1'b0;
         rb_pos_reg <= 10'h000;
         rb_data_reg <= 1'b0;
      end else if (tog_edge) begin
         // a toggle starts normal operation and closes the readback window
         rb_active_reg <= 1'b0;
         rb_pass_reg <= 1'b0;
         rb_data_reg <= 1'b0;
      end else if (rck_rise && rb_active_reg) begin
         if (rb_pass_reg) begin
            // downstream readback follows one bit behind
            rb_data_reg <= chain_sync;
         end else begin
            rb_data_reg <= seq_bit;
            if (last_of_copy) begin
               rb_pos_reg <= 10'h000;
               rb_copy_reg <= 1'b1;
               rb_pass_reg <= rb_copy_reg;
            end else begin
               rb_pos_reg <= rb_pos_reg + 10'h001;
            end
         end
      end
   end

   // timing watch: early setup clock after reset, early readout after write
   // the watch only flags the fault; bits and edges are still taken, since the
   // port cannot tell a slow controller from a broken one
   reg [5:0] wait_cnt_reg;
   reg fault_reg;
   // the wait after reset ends at the first rising setup clock
   wire early_setup = scl_rise && !setup_valid_reg && (bit_cnt_reg == 5'h00);
   // the wait after a write is counted from the last falling setup clock
   wire early_readout = rck_rise && rb_active_reg;

   always @(posedge clk_in or negedge core_rst_n_reg) begin
      if (!core_rst_n_reg) begin
         wait_cnt_reg <= 6'h00;
         fault_reg <= 1'b0;
      end else begin
         if (scl_fall) begin
            wait_cnt_reg <= 6'h00;
         end else if (wait_cnt_reg < WAIT_CYC) begin
            wait_cnt_reg <= wait_cnt_reg + 6'h01;
         end
         // sampled edges lag the pins by the same delay, so counts line up
         if ((wait_cnt_reg < WAIT_CYC) && (early_setup || early_readout)) begin
            fault_reg <= 1'b1;
         end
      end
   end

   // internal clock prescaler as a one-cycle enable
   // the divider free-runs, so its phase after a write is not defined
   reg [1:0] div_cnt_reg;
   reg int_en_reg;

   always @(posedge clk_in or negedge core_rst_n_reg) begin
      if (!core_rst_n_reg) begin
         div_cnt_reg <= 2'h0;
         int_en_reg <= 1'b0;
      end else begin
         div_cnt_reg <= div_cnt_reg + 2'h1;
         if (setup_word_reg[`CACP_BIT_CLKDIV]) begin
            int_en_reg <= (div_cnt_reg == 2'h3);
         end else begin
            int_en_reg <= 1'b1;
         end
      end
   end

   // result word formatting
   // the narrow format keeps the upper sixteen bits, right-aligned
   reg [19:0] result_reg;

   always @(posedge clk_in or negedge core_rst_n_reg) begin
      if (!core_rst_n_reg) begin
         result_reg <= 20'h00000;
      end else if (fmt20) begin
         result_reg <= integration_toggle_result_in;
      end else begin
         result_reg <= {4'h0, integration_toggle_result_in[19:4]};
      end
   end

   assign readback_data_out = rb_data_reg;
   assign setup_word_out = setup_word_reg;
   assign setup_valid_out = setup_valid_reg;
   assign readback_active_out = rb_active_reg;
   assign int_clk_en_out = int_en_reg;
   assign range_sel_out = setup_word_reg[`CACP_BIT_RANGE_HI:`CACP_BIT_RANGE_LO];
   assign wide_format_out = fmt20;
   assign speed_grade_out = setup_word_reg[`CACP_BIT_VERSION];
   assign current_inputs_open_out = setup_word_reg[`CACP_BIT_TEST];
   assign result_word_out = result_reg;
   assign timing_fault_out = fault_reg;
endmodule

/* File: logic/cacp_defines.vh */
// constants for the configuration port of the current-input converter
`ifndef CACP_DEFINES_VH
`define CACP_DEFINES_VH

// system clock and waits, in ns and in clk_in cycles
`define CACP_CLK_NS 40
`define CACP_T_RST_NS 1000
`define CACP_RST_CYC ((`CACP_T_RST_NS + `CACP_CLK_NS - 1) / `CACP_CLK_NS)
`define CACP_T_WAIT_NS 2000
// 2 us at 40 ns, sized for the six-bit wait counter
`define CACP_WAIT_CYC 6'h32

// setup word
`define CACP_SETUP_W 16
`define CACP_SETUP_RST 16'h0000
`define CACP_BIT_CLKDIV 13
`define CACP_BIT_RANGE_HI 10
`define CACP_BIT_RANGE_LO 9
`define CACP_BIT_FORMAT 8
`define CACP_BIT_VERSION 7
`define CACP_BIT_TEST 0

// revision field, value is arbitrary
`define CACP_REVISION 4'h5

// readback layout per copy, bit positions within one copy
`define CACP_LEAD_20 10'h140
`define CACP_LEAD_16 10'h100
`define CACP_PAT_START_20 10'h238
`define CACP_PAT_START_16 10'h1c8
`define CACP_TOTAL_20 10'h280
`define CACP_TOTAL_16 10'h200
`define CACP_CHECK_PATTERN 72'h30f066012480f69055

`endif

/* File: logic/cacp_sync.v */
// two-flop synchroniser for pin inputs
`timescale 1ns/10ps
module cacp_sync #(
   parameter WIDTH = 1
) (
   input wire clk_in,
   input wire sys_rst_in,
   input wire [WIDTH-1:0] async_in,
   output wire [WIDTH-1:0] sync_out
);
   reg [WIDTH-1:0] meta_reg;
   reg [WIDTH-1:0] sync_reg;

   always @(posedge clk_in) begin
      if (sys_rst_in) begin
         meta_reg <= {WIDTH{1'b0}};
         sync_reg <= {WIDTH{1'b0}};
      end else begin
         meta_reg <= async_in;
         sync_reg <= meta_reg;
      end
   end

   assign sync_out = sync_reg;
endmodule

/* File: dv/cacp_assertions.sv */
// concurrent checks on the setup port pins
`timescale 1ns/10ps
module cacp_assertions (
   input logic clk_in,
   input logic sys_rst_in,
   input logic dev_rst_n_in,
   input logic [19:0] integration_toggle_result_in,
   input logic readback_data_out,
   input logic [15:0] setup_word_out,
   input logic setup_valid_out,
   input logic readback_active_out,
   input logic int_clk_en_out,
   input logic [1:0] range_sel_out,
   input logic wide_format_out,
   input logic current_inputs_open_out,
   input logic [19:0] result_word_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (sys_rst_in || !dev_rst_n_in);
   AST_PIN_RST: assert property (disable iff (sys_rst_in)
      !dev_rst_n_in |-> setup_word_out == 16'h0000 && !setup_valid_out) else $error("pin reset");
   AST_SYS_RST: assert property (disable iff (!dev_rst_n_in)
      sys_rst_in ##1 sys_rst_in |-> setup_word_out == 16'h0000 && !readback_active_out)
      else $error("system reset");
   AST_WORD_HOLD: assert property (
      setup_valid_out && $past(setup_valid_out) |-> $stable(setup_word_out)) else $error("word moved");
   AST_WIN_OPEN: assert property (
      $rose(setup_valid_out) |-> ##[0:1] readback_active_out) else $error("no readback window");
   AST_IDLE_ZERO: assert property (
      !readback_active_out [*2] |-> !readback_data_out) else $error("idle output not low");
   AST_RANGE: assert property (
      $stable(setup_word_out) |-> range_sel_out == setup_word_out[10:9]) else $error("range");
   AST_TEST: assert property (
      $stable(setup_word_out) |-> current_inputs_open_out == setup_word_out[0]) else $error("test");
   AST_FMT: assert property (
      $stable(setup_word_out) |-> wide_format_out == setup_word_out[8]) else $error("format");
   AST_WIDE: assert property (
      setup_valid_out && wide_format_out && $past(wide_format_out)
      |-> result_word_out == $past(integration_toggle_result_in)) else $error("wide result");
   AST_TRUNC: assert property (
      setup_valid_out && !wide_format_out && !$past(wide_format_out)
      |-> result_word_out == {4'h0, $past(integration_toggle_result_in[19:4])}) else $error("narrow result");
   AST_DIV4: assert property (
      $stable(setup_word_out) && setup_word_out[13] && int_clk_en_out
      |=> !int_clk_en_out [*3] ##1 int_clk_en_out) else $error("divide by four");
endmodule
bind cacp_config_port cacp_assertions cacp_assertions_i (.clk_in, .sys_rst_in, .dev_rst_n_in,
   .integration_toggle_result_in, .readback_data_out, .setup_word_out, .setup_valid_out, .readback_active_out,
   .int_clk_en_out, .range_sel_out, .wide_format_out, .current_inputs_open_out, .result_word_out);

/* File: dv/cacp_ctrl_model.sv */
// controller model driving the setup and readout pins
`timescale 1ns/10ps
module cacp_ctrl_model (
   input wire clk_in,
   output reg dev_rst_n_out = 1'h1,
   output reg setup_clk_out = 1'h0,
   output reg setup_data_out = 1'h0,
   output reg readout_clock_out = 1'h0,
   output reg chain_data_out = 1'h0,
   output reg integration_toggle_out = 1'h0
);
   integer i;
   task cyc(input integer n);
      repeat (n) @(posedge clk_in);
      #2;
   endtask
   task pulse_reset;
      integration_toggle_out = 1'h0;
      dev_rst_n_out = 1'h0;
      cyc(26);
      dev_rst_n_out = 1'h1;
      cyc(52);
   endtask
   // data changes with the rising phase so it has settled long before the fall
   task write_word(input [15:0] w, input integer n);
      for (i = 15; i > 15 - n; i = i - 1) begin
         setup_data_out = w[i];
         setup_clk_out = 1'h1;
         cyc(4);
         setup_clk_out = 1'h0;
         cyc(4);
      end
      // released line shows the inverse so a stale level cannot pass
      setup_data_out = ~setup_data_out;
   endtask
   task rd_edge(input c);
      chain_data_out = c;
      cyc(4);
      readout_clock_out = 1'h1;
      cyc(3);
      // the chain bit is taken by now; its inverse shows a stale level
      chain_data_out = ~c;
      cyc(3);
      readout_clock_out = 1'h0;
   endtask
   task toggle;
      integration_toggle_out = ~integration_toggle_out;
      cyc(8);
   endtask
endmodule

/* File: dv/cacp_config_port_tb.sv */
// self-checking bench for the setup port
`timescale 1ns/10ps
`include "cacp_defines.vh"
module cacp_config_port_tb;
   reg clk_in = 1'h0;
   reg sys_rst_in = 1'h1;
   reg [19:0] integration_toggle = 20'h00000;
   wire rst_n, sclk, sdat, rclk, chain, tog, rb_dat, valid, active, clk_en, wide, speed, open, fault;
   wire [15:0] word;
   wire [1:0] range;
   wire [19:0] res;
   integer n_errors = 0;
   integer num_checks = 0;
   integer i, k;
   always #20 clk_in = ~clk_in;
   cacp_ctrl_model cacp_ctrl_model_i (.clk_in(clk_in), .dev_rst_n_out(rst_n),
      .setup_clk_out(sclk), .setup_data_out(sdat), .readout_clock_out(rclk),
      .chain_data_out(chain), .integration_toggle_out(tog));
   cacp_config_port cacp_config_port_i (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
      .dev_rst_n_in(rst_n), .setup_clk_in(sclk), .setup_data_in(sdat), .readout_clock_in(rclk),
      .chain_data_in(chain), .integration_toggle_in(tog), .integration_toggle_result_in(integration_toggle),
      .readback_data_out(rb_dat), .setup_word_out(word), .setup_valid_out(valid),
      .readback_active_out(active), .int_clk_en_out(clk_en), .range_sel_out(range),
      .wide_format_out(wide), .speed_grade_out(speed), .current_inputs_open_out(open),
      .result_word_out(res), .timing_fault_out(fault));
   task chk(input [19:0] g, input [19:0] e);
      num_checks = num_checks + 1;
      if (g !== e) begin
         n_errors = n_errors + 1;
         $display("[FAIL] %0t got %h want %h", $time, g, e);
      end
   endtask
   task cy(input integer n);
      repeat (n) @(posedge clk_in);
      #2;
   endtask
   task final_report;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   function ex(input [15:0] w, input integer p);
      integer ld, pt;
      reg [3:0] rv;
      reg [71:0] pat;
      ld = w[8] ? 320 : 256;
      pt = w[8] ? 568 : 456;
      rv = `CACP_REVISION;
      pat = `CACP_CHECK_PATTERN;
      p = p % (w[8] ? 640 : 512);
      ex = 1'h0;
      if (p >= ld && p < ld + 16) ex = w[ld + 15 - p];
      if (p >= ld + 16 && p < ld + 20) ex = rv[ld + 19 - p];
      if (p >= pt) ex = pat[71 + pt - p];
   endfunction
   // two copies, then four edges of pass-through from the chain input
   task rb(input [15:0] w);
      integer n;
      n = w[8] ? 1280 : 1024;
      for (i = 0; i < n + 4; i = i + 1) begin
         cacp_ctrl_model_i.rd_edge(i[0]);
         chk(rb_dat, i < n ? ex(w, i) : i[0]);
      end
   endtask
   task setup_chk(input [15:0] w);
      chk(word, w);
      chk(range, w[10:9]);
      chk(wide, w[8]);
      chk(speed, w[7]);
      chk(open, w[0]);
      chk(active, 1);
      chk(fault, 0);
      k = 0;
      repeat (8) begin
         cy(1);
         k = k + clk_en;
      end
      chk(k, w[13] ? 2 : 8);
   endtask
   initial begin
      cy(20);
      sys_rst_in = 1'h0;
      chk(word, 0);
      cacp_ctrl_model_i.pulse_reset;
      cacp_ctrl_model_i.write_word(16'h2781, 16);
      cy(52);
      setup_chk(16'h2781);
      integration_toggle = 20'habcde;
      cy(2);
      chk(res, 20'habcde);
      rb(16'h2781);
      // results of the first four conversions after setup are not used
      repeat (4) begin
         cacp_ctrl_model_i.toggle;
         chk(active, 0);
      end
      cacp_ctrl_model_i.dev_rst_n_out = 1'h0;
      #1;
      chk(word, 0);
      cy(1);
      cacp_ctrl_model_i.pulse_reset;
      cacp_ctrl_model_i.write_word(16'h0600, 8);
      cy(52);
      chk(valid, 0);
      cacp_ctrl_model_i.pulse_reset;
      cacp_ctrl_model_i.write_word(16'h0600, 16);
      cy(52);
      setup_chk(16'h0600);
      chk(res, 20'h0abcd);
      rb(16'h0600);
      cacp_ctrl_model_i.pulse_reset;
      cacp_ctrl_model_i.write_word(16'h0001, 16);
      cacp_ctrl_model_i.rd_edge(1'h0);
      chk(fault, 1);
      final_report;
   end
   initial begin
      #3000000;
      n_errors = n_errors + 1;
      $display("[FAIL] %0t run did not finish", $time);
      final_report;
   end
endmodule
